// ===== inc/picture_unit_pkg.sv
// Function
// R1 - pixels are produced for a 640 by 480 raster at 60 frames per second
// R2 - tiles are 16 by 16 pixels, each pixel a 4-bit colour index
// R3 - a tile reference is 16 bits: 6-bit palette selector, 10-bit tile number
// R4 - pattern storage holds 1024 background tiles and 1024 sprite tiles
// R5 - background map holds 1200 references as 40 columns by 30 rows
// R6 - colour lookup has 64 palettes of 16 entries each
// R7 - up to 256 sprites, one slot each in sprite attribute memory
// R8 - slot is four 16-bit words: tile reference, X, Y, flip flags
// R9 - on a new line, slots 0 to 255 are scanned for Y <= V < Y+16
// R10 - sprite row is V-Y, or 15 minus that when flipped vertically
// R11 - horizontally flipped sprite rows are loaded in reversed pixel order
// R12 - selection stops after 16 sprites accepted, in slot order
// R13 - sprite pixels run from H equal X through H equal X+15
// R14 - lowest enabled slot wins; pixel value 0 is transparent and skipped
// R15 - background uses map entry (V>>4)*40+(H>>4) and in-tile offset of low bits
// R16 - sprite and background choice is a balanced tree of depth 5
// R17 - coordinates arrive each clock and one pixel colour leaves each clock
// R18 - palette selector and pixel index together address palette memory
package picture_unit_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int FRAME_HZ = 60;
    localparam int H_ACTIVE = 640;
    localparam int V_ACTIVE = 480;
    localparam int COORD_W = 10;
    localparam int PIX_W = 4;
    localparam int TILE_PX = 16;
    localparam int PAL_W = 6;
    localparam int TILE_W = 10;
    localparam int TILE_COUNT = 1024;
    localparam int MAP_COLS = H_ACTIVE / TILE_PX;
    localparam int MAP_ROWS = V_ACTIVE / TILE_PX;
    localparam int MAP_WORDS = MAP_COLS * MAP_ROWS;
    localparam int PAL_COUNT = 64;
    localparam int PAL_ENTRIES = 16;
    localparam int RGB_W = 24;
    localparam int SPRITES = 256;
    localparam int OAM_WORDS = SPRITES * 4;
    localparam int LINE_SPRITES = 16;
    localparam int ROW_W = TILE_PX * PIX_W;
    localparam int GFX_WORDS = TILE_COUNT * TILE_PX;
    localparam int WADDR_W = 14;
    // field positions
    localparam int REF_TILE_LSB = 0;
    localparam int REF_PAL_LSB = 10;
    localparam int OAM_REF = 0;
    localparam int OAM_X = 1;
    localparam int OAM_Y = 2;
    localparam int OAM_FLAGS = 3;
    localparam int FLIP_X_BIT = 0;
    localparam int FLIP_Y_BIT = 1;
    // memory selector on the load port
    localparam logic [2:0] SEL_MAP = 3'h0;
    localparam logic [2:0] SEL_BG_GFX = 3'h1;
    localparam logic [2:0] SEL_SPR_GFX = 3'h2;
    localparam logic [2:0] SEL_PAL = 3'h3;
    localparam logic [2:0] SEL_OAM = 3'h4;
    localparam logic [4:0] CNT_RESET = 5'h00;
    localparam logic [COORD_W-1:0] V_RESET = 10'h3FF;
    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_TEST = 3'b010,
        SCAN_FETCH = 3'b100
    } scan_state_t;
endpackage

// ===== rtl/picture_unit.sv
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("pixel_fifo: bad WIDTH or DEPTH");
    end
    // head word sits in its own register so that every output leaves a flip-flop
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] head_reg;
    logic head_valid_reg;
    logic ready_reg;
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic [AW:0] total_next;
    logic head_valid_next;
    logic push;
    logic pop;
    logic head_free;
    logic direct;
    logic stash;
    logic unstash;
    assign in_ready = ready_reg;
    assign out_valid = head_valid_reg;
    assign out_data = head_reg;
    assign push = in_valid && ready_reg;
    assign pop = head_valid_reg && out_ready;
    assign head_free = !head_valid_reg || pop;
    // an empty store lets a word go straight to the head
    assign direct = push && head_free && cnt_reg == '0;
    assign stash = push && !direct;
    assign unstash = head_free && cnt_reg != '0;
    assign head_valid_next = (head_valid_reg && !pop) || direct || unstash;
    assign cnt_next = cnt_reg + (AW+1)'(stash) - (AW+1)'(unstash);
    assign total_next = cnt_next + (AW+1)'(head_valid_next);
    always_ff @(posedge mclk) begin
        if (stash) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge mclk) begin
        if (direct) begin
            head_reg <= in_data;
        end else if (unstash) begin
            head_reg <= mem[rd_reg];
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + AW'(stash);
            rd_reg <= rd_reg + AW'(unstash);
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            head_valid_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            head_valid_reg <= head_valid_next;
            // full is judged one edge ahead, so no gate sits behind the ready flop
            ready_reg <= total_next != (AW+1)'(DEPTH);
        end
    end
endmodule // pixel_fifo

module picture_unit #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // coordinates from the timing controller
    input wire logic coord_valid,
    output logic coord_ready,
    input wire logic [picture_unit_pkg::COORD_W-1:0] coord_h,
    input wire logic [picture_unit_pkg::COORD_W-1:0] coord_v,
    // memory load port
    input wire logic load_en,
    input wire logic [2:0] load_sel,
    input wire logic [picture_unit_pkg::WADDR_W-1:0] load_addr,
    input wire logic [picture_unit_pkg::ROW_W-1:0] load_data,
    // pixel stream out
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [picture_unit_pkg::RGB_W-1:0] pix_rgb
);
    import picture_unit_pkg::*;
    initial begin
        if (FIFO_DEPTH < 2) $error("picture_unit: FIFO_DEPTH too small");
    end

    logic [15:0] map_mem [MAP_WORDS];
    logic [ROW_W-1:0] bg_mem [GFX_WORDS];
    logic [ROW_W-1:0] spr_mem [GFX_WORDS];
    logic [RGB_W-1:0] pal_mem [PAL_COUNT*PAL_ENTRIES];
    logic [15:0] sprite_attribute_memory [OAM_WORDS];

    // load port; memories stay uninitialised, software fills them
    always_ff @(posedge mclk) begin
        if (load_en) begin
            case (load_sel)
                SEL_MAP: map_mem[load_addr[10:0]] <= load_data[15:0]; // R5
                SEL_BG_GFX: bg_mem[load_addr] <= load_data; // R4
                SEL_SPR_GFX: spr_mem[load_addr] <= load_data; // R4
                SEL_PAL: pal_mem[load_addr[9:0]] <= load_data[RGB_W-1:0]; // R6
                SEL_OAM: sprite_attribute_memory[load_addr[9:0]] <= load_data[15:0]; // R7
                default: ;
            endcase
        end
    end

    logic adv;
    logic take;
    assign coord_ready = adv;
    assign take = coord_valid && adv;

    // per-line sprite list
    logic [COORD_W-1:0] line_x [LINE_SPRITES];
    logic [PAL_W-1:0] line_pal [LINE_SPRITES];
    logic [ROW_W-1:0] line_row [LINE_SPRITES];
    logic [4:0] line_cnt_reg;
    scan_state_t scan_reg;
    logic [7:0] slot_reg;
    logic [COORD_W-1:0] last_v_reg;
    logic [COORD_W-1:0] scan_v_reg;
    logic [COORD_W-1:0] pend_x_reg;
    logic [PAL_W-1:0] pend_pal_reg;
    logic pend_flip_reg;
    logic [ROW_W-1:0] spr_q;
    logic new_line;
    assign new_line = take && coord_v != last_v_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_v_reg <= V_RESET;
        end else if (take) begin
            last_v_reg <= coord_v;
        end
    end

    // attribute words of the slot under test
    logic [15:0] a_ref;
    logic [15:0] a_x;
    logic [15:0] a_y;
    logic [15:0] a_flags;
    logic [15:0] dy;
    logic hit_y;
    logic [3:0] flip_y_row;
    logic flip_y_flag;
    logic flip_x_flag;
    assign a_ref = sprite_attribute_memory[{slot_reg, 2'(OAM_REF)}]; // R8
    assign a_x = sprite_attribute_memory[{slot_reg, 2'(OAM_X)}];
    assign a_y = sprite_attribute_memory[{slot_reg, 2'(OAM_Y)}];
    assign a_flags = sprite_attribute_memory[{slot_reg, 2'(OAM_FLAGS)}];
    assign flip_y_flag = a_flags[FLIP_Y_BIT];
    assign flip_x_flag = a_flags[FLIP_X_BIT];
    assign dy = {6'h00, scan_v_reg} - a_y;
    assign hit_y = ({6'h00, scan_v_reg} >= a_y) && (dy < 16'(TILE_PX)); // R9
    assign flip_y_row = flip_y_flag ? 4'hF - dy[3:0] : dy[3:0]; // R10

    // one slot per cycle; a hit costs one extra cycle for the row fetch
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scan_reg <= SCAN_IDLE;
            slot_reg <= 8'h00;
            scan_v_reg <= '0;
            line_cnt_reg <= CNT_RESET;
            pend_x_reg <= '0;
            pend_pal_reg <= '0;
            pend_flip_reg <= 1'b0;
        end else if (new_line) begin
            scan_reg <= SCAN_TEST; // R9
            slot_reg <= 8'h00;
            scan_v_reg <= coord_v;
            line_cnt_reg <= CNT_RESET;
        end else begin
            case (scan_reg)
                SCAN_IDLE: ;
                SCAN_TEST: begin
                    if (hit_y) begin
                        scan_reg <= SCAN_FETCH;
                        pend_x_reg <= a_x[COORD_W-1:0];
                        pend_pal_reg <= a_ref[REF_PAL_LSB +: PAL_W]; // R3
                        pend_flip_reg <= flip_x_flag;
                    end else if (slot_reg == 8'hFF) begin
                        scan_reg <= SCAN_IDLE;
                    end else begin
                        slot_reg <= slot_reg + 8'h01;
                    end
                end
                SCAN_FETCH: begin
                    line_cnt_reg <= line_cnt_reg + 5'h01;
                    if (line_cnt_reg == 5'(LINE_SPRITES - 1) || slot_reg == 8'hFF) begin
                        scan_reg <= SCAN_IDLE; // R12
                    end else begin
                        scan_reg <= SCAN_TEST;
                        slot_reg <= slot_reg + 8'h01;
                    end
                end
                default: scan_reg <= SCAN_IDLE;
            endcase
        end
    end

    // row address = tile*16 + row, i.e. tile number scaled by 16 rows
    always_ff @(posedge mclk) begin
        spr_q <= spr_mem[{a_ref[REF_TILE_LSB +: TILE_W], flip_y_row}]; // R10
    end

    // list entries; reversal happens once at load, not per pixel
    genvar gi;
    generate
        for (gi = 0; gi < LINE_SPRITES; gi++) begin : g_load
            logic [ROW_W-1:0] rev;
            for (genvar p = 0; p < TILE_PX; p++) begin : g_rev
                assign rev[p*PIX_W +: PIX_W] = spr_q[(TILE_PX-1-p)*PIX_W +: PIX_W];
            end
            always_ff @(posedge mclk) begin
                if (scan_reg == SCAN_FETCH && !new_line && line_cnt_reg == 5'(gi)) begin
                    line_x[gi] <= pend_x_reg;
                    line_pal[gi] <= pend_pal_reg;
                    line_row[gi] <= pend_flip_reg ? rev : spr_q; // R11
                end
            end
        end
    endgenerate

    // candidates: {opaque, palette, index}
    localparam int CW = 1 + PAL_W + PIX_W;
    logic [CW-1:0] cand [5][LINE_SPRITES];
    generate
        for (gi = 0; gi < LINE_SPRITES; gi++) begin : g_cand
            logic [COORD_W-1:0] dx;
            logic on;
            logic [PIX_W-1:0] px;
            assign dx = coord_h - line_x[gi];
            assign on = (5'(gi) < line_cnt_reg) && (coord_h >= line_x[gi])
                && (dx < COORD_W'(TILE_PX)); // R13
            assign px = PIX_W'(line_row[gi] >> {dx[3:0], 2'b00}); // R13
            assign cand[0][gi] = {on && px != '0, line_pal[gi], px}; // R14
        end
        for (genvar l = 0; l < 4; l++) begin : g_lvl
            for (gi = 0; gi < (LINE_SPRITES >> (l + 1)); gi++) begin : g_node
                // lower slot sits left and wins when opaque
                assign cand[l+1][gi] = cand[l][2*gi][CW-1] ? cand[l][2*gi] : cand[l][2*gi+1]; // R16
            end
            for (gi = (LINE_SPRITES >> (l + 1)); gi < LINE_SPRITES; gi++) begin : g_pad
                assign cand[l+1][gi] = '0;
            end
        end
    endgenerate

    // pixel pipeline, all stages hold while the fifo is full
    logic [10:0] background_map_index;
    logic [7:0] tile_pixel_offset_a;
    logic v1_reg, v2_reg, v3_reg, v4_reg;
    logic b1_reg, b2_reg, b3_reg;
    logic [7:0] off1_reg;
    logic [3:0] h2_reg;
    logic [CW-1:0] w1_reg, w2_reg;
    logic [15:0] map_q;
    logic [ROW_W-1:0] bg_q;
    logic [PAL_W-1:0] pal2_reg;
    logic [9:0] pal_addr_reg;
    logic [RGB_W-1:0] rgb4_reg;
    logic [PIX_W-1:0] bg_px;
    assign background_map_index = 11'((coord_v >> 4) * MAP_COLS + (coord_h >> 4)); // R15
    assign tile_pixel_offset_a = {coord_v[3:0], coord_h[3:0]}; // R15
    assign bg_px = PIX_W'(bg_q >> {h2_reg, 2'b00});

    always_ff @(posedge mclk) begin
        if (adv) begin
            map_q <= map_mem[background_map_index]; // R5
            bg_q <= bg_mem[{map_q[REF_TILE_LSB +: TILE_W], off1_reg[7:4]}]; // R2
            rgb4_reg <= b3_reg ? '0 : pal_mem[pal_addr_reg]; // R18
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            v1_reg <= 1'b0;
            v2_reg <= 1'b0;
            v3_reg <= 1'b0;
            v4_reg <= 1'b0;
            b1_reg <= 1'b0;
            b2_reg <= 1'b0;
            b3_reg <= 1'b0;
            off1_reg <= '0;
            h2_reg <= '0;
            w1_reg <= '0;
            w2_reg <= '0;
            pal2_reg <= '0;
            pal_addr_reg <= '0;
        end else if (adv) begin
            v1_reg <= take; // R17
            b1_reg <= coord_h >= COORD_W'(H_ACTIVE) || coord_v >= COORD_W'(V_ACTIVE); // R1
            off1_reg <= tile_pixel_offset_a;
            w1_reg <= cand[4][0];
            v2_reg <= v1_reg;
            b2_reg <= b1_reg;
            h2_reg <= off1_reg[3:0];
            w2_reg <= w1_reg;
            pal2_reg <= map_q[REF_PAL_LSB +: PAL_W]; // R3
            v3_reg <= v2_reg;
            b3_reg <= b2_reg;
            // fifth level: sprite winner against background
            pal_addr_reg <= w2_reg[CW-1] ? w2_reg[CW-2:0] : {pal2_reg, bg_px}; // R16
            v4_reg <= v3_reg;
        end
    end

    pixel_fifo #(
        .WIDTH(RGB_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(v4_reg),
        .in_ready(adv),
        .in_data(rgb4_reg),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix_rgb)
    ); // R17
endmodule // picture_unit

// ===== verif/coord_source.sv
`timescale 1ns/1ps
module coord_source (
    // clock
    input wire logic mclk,
    // coordinate handshake
    output logic coord_valid,
    input wire logic coord_ready,
    output logic [picture_unit_pkg::COORD_W-1:0] coord_h,
    output logic [picture_unit_pkg::COORD_W-1:0] coord_v
);
    import picture_unit_pkg::*;
    initial begin
        coord_valid = 1'b0;
        coord_h = 10'h3FF;
        coord_v = 10'h3FF;
    end
    // scrambled while idle so the renderer cannot lean on stale values
    task automatic idle();
        coord_valid = 1'b0;
        coord_h = ~coord_h;
        coord_v = ~coord_v;
    endtask
    // called at a falling edge; one coordinate a clock, or every other clock when slow
    task automatic send(input logic [COORD_W-1:0] h0, input logic [COORD_W-1:0] v0, input int n,
                        input bit slow, output bit ok);
        int k;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            coord_valid = 1'b1;
            coord_h = h0 + COORD_W'(i);
            coord_v = v0;
            k = 0;
            while (!coord_ready && k < 2000) begin
                @(negedge mclk);
                k++;
            end
            if (k == 2000) begin
                ok = 1'b0;
                break;
            end
            @(negedge mclk);
            if (slow) begin
                idle();
                @(negedge mclk);
            end
        end
        idle();
    endtask
endmodule // coord_source

// ===== verif/picture_unit_chk.sv
`timescale 1ns/1ps
module picture_unit_chk #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // handshakes
    input wire logic coord_valid,
    input wire logic coord_ready,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic [picture_unit_pkg::RGB_W-1:0] pix_rgb
);
    import picture_unit_pkg::*;
    int pending;
    // coordinates taken but whose pixel has not yet left
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            pending <= 0;
        else
            pending <= pending + int'(coord_valid && coord_ready) - int'(pix_valid && pix_ready);
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_RESET_OUT: assert property ($rose(rstn) |-> coord_ready && !pix_valid)
        else $error("outputs not idle after reset");
    AST_PIX_HOLD: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_rgb))
        else $error("pixel changed while stalled");
    AST_FIRST_PIX: assert property (coord_valid && coord_ready && pending == 0 |=> !pix_valid [*4] ##1 pix_valid)
        else $error("pixel latency wrong");
    AST_FULL_VALID: assert property (!coord_ready |-> pix_valid)
        else $error("refusing with empty output");
    AST_READY_FALL: assert property ($fell(coord_ready) |-> $past(pix_valid) && !$past(pix_ready))
        else $error("ready fell without stall");
    AST_READY_BACK: assert property (!coord_ready && pix_valid && pix_ready |=> coord_ready)
        else $error("ready not restored after pop");
    AST_NO_ORPHAN: assert property (pix_valid |-> pending != 0)
        else $error("pixel without coordinate");
    AST_IN_FLIGHT: assert property (pending <= FIFO_DEPTH + 4)
        else $error("too many coordinates taken");
    AST_LAST_DROP: assert property (pix_valid && pix_ready && pending == 1 && !coord_valid |=> !pix_valid)
        else $error("extra pixel after last");
endmodule // picture_unit_chk
bind picture_unit picture_unit_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.mclk(mclk), .rstn(rstn),
    .coord_valid(coord_valid), .coord_ready(coord_ready), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_rgb(pix_rgb));

// ===== verif/tb_picture_unit.sv
`timescale 1ns/1ps
module tb_picture_unit;
    import picture_unit_pkg::*;
    logic mclk = 1'b0;
    logic rstn;
    logic load_en;
    logic pix_ready;
    logic [2:0] load_sel;
    logic [WADDR_W-1:0] load_addr;
    logic [ROW_W-1:0] load_data;
    logic coord_valid;
    logic coord_ready;
    logic pix_valid;
    logic [COORD_W-1:0] coord_h;
    logic [COORD_W-1:0] coord_v;
    logic [RGB_W-1:0] pix_rgb;
    logic [RGB_W-1:0] expq[$];
    int n_errors = 0;
    int check_count = 0;
    int sx[256];
    int sy[256];
    logic [15:0] sf[256];
    logic [15:0] sr[256];
    always #25 mclk = ~mclk;
    picture_unit #(.FIFO_DEPTH(16)) u_dut (.mclk(mclk), .rstn(rstn), .coord_valid(coord_valid),
        .coord_ready(coord_ready), .coord_h(coord_h), .coord_v(coord_v), .load_en(load_en), .load_sel(load_sel),
        .load_addr(load_addr), .load_data(load_data), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_rgb(pix_rgb));
    coord_source u_src (.mclk(mclk), .coord_valid(coord_valid), .coord_ready(coord_ready), .coord_h(coord_h),
        .coord_v(coord_v));
    function automatic logic [RGB_W-1:0] color(input int p, input int i);
        return {2'h0, 6'(p), 4'h0, 4'(i), 8'h5A};
    endfunction
    function automatic logic [3:0] bpix(input int t, input int r, input int c);
        return 4'(3 * t + r + c);
    endfunction
    // tile 6 is mostly opaque, tile 5 has a transparent left edge
    function automatic logic [3:0] spix(input int t, input int r, input int c);
        return t == 6 ? 4'(c + 1) : (c < 3 ? 4'h0 : 4'(r + c));
    endfunction
    function automatic logic [RGB_W-1:0] exp_rgb(input int h, input int v);
        int cnt;
        int r;
        int c;
        logic [3:0] px;
        cnt = 0;
        if (h >= 640 || v >= 480)
            return 24'h000000;
        for (int s = 0; s < 256 && cnt < 16; s++) begin
            if (v >= sy[s] && v < sy[s] + 16) begin
                cnt++;
                r = sf[s][FLIP_Y_BIT] ? 15 - (v - sy[s]) : v - sy[s];
                c = sf[s][FLIP_X_BIT] ? 15 - (h - sx[s]) : h - sx[s];
                px = spix(sr[s][9:0], r, c);
                if (h >= sx[s] && h <= sx[s] + 15 && px != 4'h0)
                    return color(sr[s][15:10], px);
            end
        end
        return color(1, bpix((v / 16 * 40 + h / 16) % 4, v % 16, h % 16));
    endfunction
    task automatic chk24(input string what, input logic [RGB_W-1:0] e, input logic [RGB_W-1:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h got %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %b got %b", what, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (coord_valid && coord_ready)
            expq.push_back(exp_rgb(coord_h, coord_v));
        if (pix_valid && pix_ready && expq.size() != 0)
            chk24("pix_rgb", expq.pop_front(), pix_rgb);
        else if (pix_valid && pix_ready)
            chk1("pix_valid spare", 1'b0, pix_valid);
    end
    task automatic ld(input logic [2:0] sel, input int a, input logic [ROW_W-1:0] d);
        load_en = 1'b1;
        load_sel = sel;
        load_addr = WADDR_W'(a);
        load_data = d;
        @(negedge mclk);
    endtask
    task automatic set_spr(input int s, input int x, input int y, input int f, input int t, input int p);
        sx[s] = x;
        sy[s] = y;
        sf[s] = 16'(f);
        sr[s] = {6'(p), 10'(t)};
        ld(SEL_OAM, s * 4, 64'(sr[s]));
        ld(SEL_OAM, s * 4 + 1, 64'(x));
        ld(SEL_OAM, s * 4 + 2, 64'(y));
        ld(SEL_OAM, s * 4 + 3, 64'(f));
    endtask
    task automatic setup();
        logic [ROW_W-1:0] row;
        for (int i = 0; i < 1024; i++)
            ld(SEL_PAL, i, 64'(color(i / 16, i % 16)));
        for (int i = 0; i < 1200; i++)
            ld(SEL_MAP, i, {48'h0, 6'h01, 10'(i % 4)});
        for (int t = 0; t < 7; t++) begin
            for (int r = 0; r < 16; r++) begin
                for (int c = 0; c < 16; c++)
                    row[4 * c +: 4] = t < 4 ? bpix(t, r, c) : spix(t, r, c);
                ld(t < 4 ? SEL_BG_GFX : SEL_SPR_GFX, t * 16 + r, row);
            end
        end
        // parked below every line in both 10-bit and 16-bit readings
        for (int s = 0; s < 256; s++)
            set_spr(s, 0, 1008, 0, 5, 2);
    endtask
    // blanking coordinates first give the line scan time to finish
    task automatic run_line(input int v, input int h0, input int n, input bit slow, input bit stall);
        bit ok;
        int k;
        load_en = 1'b0;
        pix_ready = !stall;
        fork
            begin
                u_src.send(10'h280, 10'(v), 300, 1'b0, ok);
                // idle clock between bursts
                @(negedge mclk);
                if (ok)
                    u_src.send(10'(h0), 10'(v), n, slow, ok);
            end
            if (stall) begin
                k = 0;
                while (coord_ready && k < 500) begin
                    @(negedge mclk);
                    k++;
                end
                chk1("coord_ready full", 1'b0, coord_ready);
                repeat (3) @(negedge mclk);
                pix_ready = 1'b1;
            end
        join
        k = 0;
        while (expq.size() != 0 && k < 500) begin
            @(negedge mclk);
            k++;
        end
        chk1("line done", 1'b1, ok && expq.size() == 0);
        if (!ok || expq.size() != 0)
            results();
    endtask
    task automatic sc_background();
        run_line(37, 0, 64, 1'b0, 1'b0);
        run_line(479, 600, 48, 1'b0, 1'b0);
    endtask
    task automatic sc_flips();
        for (int s = 0; s < 5; s++)
            set_spr(s, 10 + 30 * s, 85 + 4 * s, s % 4, 5, 2 + s);
        set_spr(5, 170, 84, 1, 5, 2);
        set_spr(6, 200, 100, 0, 5, 2);
        run_line(100, 0, 240, 1'b0, 1'b0);
    endtask
    task automatic sc_priority();
        set_spr(7, 50, 195, 0, 5, 2);
        set_spr(9, 56, 190, 3, 6, 3);
        run_line(200, 40, 40, 1'b1, 1'b0);
    endtask
    task automatic sc_limit();
        for (int s = 20; s < 38; s++)
            set_spr(s, (s - 20) * 32, 300, 0, 6, 3);
        run_line(300, 0, 640, 1'b0, 1'b1);
    endtask
    initial begin
        rstn = 1'b0;
        load_en = 1'b0;
        load_sel = 3'h0;
        load_addr = 14'h0000;
        load_data = 64'h0;
        pix_ready = 1'b1;
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        chk1("coord_ready", 1'b1, coord_ready);
        chk1("pix_valid", 1'b0, pix_valid);
        setup();
        sc_background();
        sc_flips();
        sc_priority();
        sc_limit();
        results();
    end
endmodule // tb_picture_unit
